// file: rtl/lpbst_params.svh
// Timing counts, bank count and reset values of the bank state tracker.
// Assumes a 25 MHz command clock; times are in picoseconds or in clocks.
`ifndef LPBST_PARAMS_SVH
`define LPBST_PARAMS_SVH

`define LPBST_NUM_BANKS   8
`define LPBST_TCK_PS      40000
`define LPBST_CEIL(ps)    (((ps) + `LPBST_TCK_PS - 1) / `LPBST_TCK_PS)

`define LPBST_TRCD_PS     18000
`define LPBST_TRP_PS      18000
`define LPBST_TRFCPB_PS   90000
`define LPBST_TRFCAB_PS   130000
`define LPBST_TINIT5_PS   10000000
`define LPBST_TMRR_CK     2
`define LPBST_TMRW_CK     5

`define LPBST_TRCD_CYC    `LPBST_CEIL(`LPBST_TRCD_PS)
`define LPBST_TRP_CYC     `LPBST_CEIL(`LPBST_TRP_PS)
`define LPBST_TRFCPB_CYC  `LPBST_CEIL(`LPBST_TRFCPB_PS)
`define LPBST_TRFCAB_CYC  `LPBST_CEIL(`LPBST_TRFCAB_PS)
`define LPBST_TINIT5_CYC  `LPBST_CEIL(`LPBST_TINIT5_PS)

`define LPBST_CNT_W       8
`define LPBST_RST_STATE   ST_POWER_ON

`endif

// file: rtl/lpbst_pkg.sv
// Types shared by the bank state tracker and its per-bank timer.
// Assumes lpbst_params.svh supplies the numeric constants.
package lpbst_pkg;

  typedef enum logic [3:0] {
    ST_IDLE       = 4'h0,
    ST_ACTIVATING = 4'h1,
    ST_ACTIVE     = 4'h2,
    ST_READING    = 4'h3,
    ST_WRITING    = 4'h4,
    ST_RD_AP      = 4'h5,
    ST_WR_AP      = 4'h6,
    ST_PRECHARGE  = 4'h7,
    ST_REF_PB     = 4'h8,
    ST_REF_AB     = 4'h9,
    ST_MRR_IDLE   = 4'hA,
    ST_MRR_ACTIVE = 4'hB,
    ST_MRR_RESET  = 4'hC,
    ST_MR_WRITING = 4'hD,
    ST_RESETTING  = 4'hE,
    ST_POWER_ON   = 4'hF
  } lpbst_state_t;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ACT = 4'h1,
    CMD_RD  = 4'h2,
    CMD_WR  = 4'h3,
    CMD_PRE = 4'h4,
    CMD_REF = 4'h5,
    CMD_MRR = 4'h6,
    CMD_MRW = 4'h7,
    CMD_BST = 4'h8
  } lpbst_cmd_t;

endpackage

// file: rtl/lpbst_bank.sv
// State register and down-counter of one bank.
// Assumes the tracker decides every load; expiry is handled here.
`timescale 1ns/1ps
`include "lpbst_params.svh"
module lpbst_bank (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic                     clk_en,
  // Load from the tracker
  input  wire logic                     load,
  input  wire lpbst_pkg::lpbst_state_t  load_state,
  input  wire logic [`LPBST_CNT_W-1:0]  load_count,
  input  wire lpbst_pkg::lpbst_state_t  load_ret,
  // Bank state
  output lpbst_pkg::lpbst_state_t       state
);
  import lpbst_pkg::*;

  logic [`LPBST_CNT_W-1:0] cnt;
  lpbst_state_t            ret;

  // ==========================================================
  // Timer: zero means the state is untimed
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
    end else if (clk_en) begin
      if (load) begin
        cnt <= load_count;
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ret <= ST_IDLE;
    end else if (clk_en && load) begin
      ret <= load_ret;
    end
  end

  // ==========================================================
  // State
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= `LPBST_RST_STATE;
    end else if (clk_en) begin
      if (load) begin
        state <= load_state;
      end else if (cnt == `LPBST_CNT_W'(1)) begin
        state <= ret;
      end
    end
  end

  a_timer_expiry: assert property (@(posedge clk_sys iff clk_en) disable iff (sys_rst)
    (cnt == `LPBST_CNT_W'(1) && !load) |=> (state == $past(ret) && cnt == '0))
    else $error("bank did not leave timed state at count expiry");

endmodule

// file: rtl/lpbst_tracker.sv
// Per-bank and device-wide command state tracker of the memory device.
// Assumes commands arrive decoded, one per clock, from logic on clk_sys;
// burst_end is a one-cycle pulse from the data path when a burst finishes.
`timescale 1ns/1ps
`include "lpbst_params.svh"
module lpbst_tracker (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  // Decoded command
  input  wire logic                  cke,
  input  wire lpbst_pkg::lpbst_cmd_t cmd,
  input  wire logic [2:0]            cmd_bank,
  input  wire logic                  cmd_all,
  input  wire logic                  cmd_ap,
  input  wire logic                  cmd_rst_mr,
  // Data path
  input  wire logic                  burst_end,
  // Status
  output logic [31:0]                bank_state,
  output logic                       all_idle,
  output logic                       burst_live,
  output logic                       cmd_illegal
);
  import lpbst_pkg::*;

  localparam int NB = `LPBST_NUM_BANKS;

  lpbst_state_t            st     [NB];
  logic                    ld     [NB];
  lpbst_state_t            ld_st  [NB];
  logic [`LPBST_CNT_W-1:0] ld_cnt [NB];
  lpbst_state_t            ld_ret [NB];

  logic         cke_prev;
  logic [2:0]   last_bank;
  logic         legal;
  logic         acc;
  logic         all_idle_now;
  logic         any_open;
  logic         mrr_ok;
  logic         pre_all_ok;
  logic         dw;
  logic         ap_hold;
  lpbst_state_t tgt;
  lpbst_state_t dev;

  // ==========================================================
  // Decoders
  function automatic logic pre_ok(lpbst_state_t s);
    return (s == ST_IDLE) || (s == ST_ACTIVE);
  endfunction

  function automatic logic dev_wide(lpbst_state_t s);
    return (s == ST_REF_AB) || (s == ST_MRR_IDLE) || (s == ST_MRR_RESET) ||
           (s == ST_MR_WRITING) || (s == ST_RESETTING) || (s == ST_POWER_ON);
  endfunction

  // ==========================================================
  // Device summary
  always_comb begin
    all_idle_now = 1'b1;
    any_open     = 1'b0;
    pre_all_ok   = 1'b1;
    mrr_ok       = 1'b1;
    for (int i = 0; i < NB; i++) begin
      all_idle_now = all_idle_now && (st[i] == ST_IDLE);
      any_open     = any_open || (st[i] == ST_ACTIVE) ||
                     (st[i] == ST_READING) || (st[i] == ST_WRITING);
      pre_all_ok   = pre_all_ok && pre_ok(st[i]);
      mrr_ok       = mrr_ok && (pre_ok(st[i]) || (st[i] == ST_ACTIVATING) ||
                     (st[i] == ST_PRECHARGE));
    end
  end

  assign tgt = st[cmd_bank];
  assign dev = st[0];
  assign dw  = dev_wide(dev);

  // A bank whose burst still runs takes no activate or single-bank precharge; other banks still take them
  assign ap_hold = burst_live && (last_bank == cmd_bank);

  // ==========================================================
  // Legality: busy banks refuse, illegal commands are dropped
  always_comb begin
    unique case (cmd)
      CMD_NOP: legal = 1'b1;
      CMD_ACT: legal = !dw && (tgt == ST_IDLE) && !ap_hold;
      CMD_RD:  legal = !dw && ((tgt == ST_ACTIVE) || (tgt == ST_READING));
      CMD_WR:  legal = !dw && ((tgt == ST_ACTIVE) || (tgt == ST_WRITING));
      CMD_PRE: legal = !dw && (cmd_all ? pre_all_ok : (pre_ok(tgt) && !ap_hold));
      CMD_REF: legal = !burst_live && (cmd_all ? all_idle_now
                                               : (!dw && tgt == ST_IDLE));
      CMD_MRR: legal = (dev == ST_RESETTING) ||
                       (!dw && mrr_ok && !burst_live);
      CMD_MRW: legal = (all_idle_now && !burst_live) ||
                       (cmd_rst_mr && dev == ST_POWER_ON);
      CMD_BST: legal = !dw && burst_live;
      default: legal = 1'b0;
    endcase
  end

  // Only edges with clock enable high now and before carry commands
  assign acc = cke_prev && cke && (cmd != CMD_NOP) && legal;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cke_prev <= 1'b0;
    end else if (clk_en) begin
      cke_prev <= cke;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_illegal <= 1'b0;
    end else if (clk_en) begin
      cmd_illegal <= cke_prev && cke && (cmd != CMD_NOP) && !legal;
    end
  end

  // ==========================================================
  // Burst tracking; a new burst wins over the end of the old one
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      burst_live <= 1'b0;
      last_bank  <= 3'h0;
    end else if (clk_en) begin
      if (acc && (cmd == CMD_RD || cmd == CMD_WR)) begin
        burst_live <= 1'b1;
        last_bank  <= cmd_bank;
      end else if ((acc && cmd == CMD_BST) || burst_end) begin
        burst_live <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      all_idle <= 1'b0;
    end else if (clk_en) begin
      all_idle <= all_idle_now;
    end
  end

  // ==========================================================
  // Per-bank loads and timers
  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic hit;
    logic ends;
    assign hit  = (cmd_bank == 3'(b));
    assign ends = (last_bank == 3'(b)) && burst_live &&
                  ((st[b] == ST_READING) || (st[b] == ST_WRITING));

    always_comb begin
      ld[b]     = 1'b0;
      ld_st[b]  = st[b];
      ld_cnt[b] = '0;
      ld_ret[b] = ST_IDLE;
      if (acc) begin
        unique case (cmd)
          CMD_ACT: if (hit) begin
            ld[b] = 1'b1; ld_st[b] = ST_ACTIVATING; ld_ret[b] = ST_ACTIVE;
            ld_cnt[b] = `LPBST_CNT_W'(`LPBST_TRCD_CYC);
          end
          CMD_RD, CMD_WR: if (hit) begin
            ld[b] = 1'b1;
            if (cmd_ap) begin
              ld_st[b]  = (cmd == CMD_RD) ? ST_RD_AP : ST_WR_AP;
              ld_cnt[b] = `LPBST_CNT_W'(`LPBST_TRP_CYC);
            end else begin
              ld_st[b]  = (cmd == CMD_RD) ? ST_READING : ST_WRITING;
            end
          end
          CMD_PRE: if (cmd_all || hit) begin
            ld[b] = 1'b1; ld_st[b] = ST_PRECHARGE;
            ld_cnt[b] = `LPBST_CNT_W'(`LPBST_TRP_CYC);
          end
          CMD_REF: if (cmd_all) begin
            ld[b] = 1'b1; ld_st[b] = ST_REF_AB;
            ld_cnt[b] = `LPBST_CNT_W'(`LPBST_TRFCAB_CYC);
          end else if (hit) begin
            ld[b] = 1'b1; ld_st[b] = ST_REF_PB;
            ld_cnt[b] = `LPBST_CNT_W'(`LPBST_TRFCPB_CYC);
          end
          CMD_MRW: begin
            ld[b] = 1'b1;
            if (cmd_rst_mr) begin
              ld_st[b]  = ST_RESETTING;
              ld_cnt[b] = `LPBST_CNT_W'(`LPBST_TINIT5_CYC);
            end else begin
              ld_st[b]  = ST_MR_WRITING;
              ld_cnt[b] = `LPBST_CNT_W'(`LPBST_TMRW_CK);
            end
          end
          CMD_MRR: begin
            ld_cnt[b] = `LPBST_CNT_W'(`LPBST_TMRR_CK);
            if (dev == ST_RESETTING) begin
              ld[b] = 1'b1; ld_st[b] = ST_MRR_RESET;
            end else if (st[b] == ST_ACTIVE) begin
              ld[b] = 1'b1; ld_st[b] = ST_MRR_ACTIVE; ld_ret[b] = ST_ACTIVE;
            end else if (!any_open && st[b] == ST_IDLE) begin
              ld[b] = 1'b1; ld_st[b] = ST_MRR_IDLE;
            end
          end
          CMD_BST: if (ends) begin
            ld[b] = 1'b1; ld_st[b] = ST_ACTIVE;
          end
          default: ;
        endcase
      end
      if (!ld[b] && burst_end && ends) begin
        ld[b] = 1'b1; ld_st[b] = ST_ACTIVE;
      end
    end

    lpbst_bank u_bank (
      .clk_sys    (clk_sys),
      .sys_rst    (sys_rst),
      .clk_en     (clk_en),
      .load       (ld[b]),
      .load_state (ld_st[b]),
      .load_count (ld_cnt[b]),
      .load_ret   (ld_ret[b]),
      .state      (st[b])
    );

    assign bank_state[4*b +: 4] = st[b];
  end

  // ==========================================================
  // Checks on bank 0; frozen cycles are skipped
  default clocking cb @(posedge clk_sys iff clk_en); endclocking
  default disable iff (sys_rst);

  logic hit0;
  assign hit0 = acc && (cmd_bank == 3'h0);

  a_refpb_hold: assert property (hit0 && cmd == CMD_REF && !cmd_all |=>
    (st[0] == ST_REF_PB) [*3] ##1 (st[0] == ST_IDLE))
    else $error("per-bank refresh length wrong");
  a_refab_hold: assert property (acc && cmd == CMD_REF && cmd_all |=>
    (st[0] == ST_REF_AB && st[NB-1] == ST_REF_AB) [*4] ##1 all_idle_now ##1 all_idle)
    else $error("all-bank refresh length wrong");
  a_mrr_idle: assert property (acc && cmd == CMD_MRR && all_idle_now |=>
    (st[0] == ST_MRR_IDLE) [*2] ##1 (st[0] == ST_IDLE))
    else $error("idle register read length wrong");
  a_mrr_active: assert property (acc && cmd == CMD_MRR && st[0] == ST_ACTIVE |=>
    (st[0] == ST_MRR_ACTIVE) [*2] ##1 (st[0] == ST_ACTIVE))
    else $error("active register read did not return active");
  a_mrw_hold: assert property (acc && cmd == CMD_MRW && !cmd_rst_mr |=>
    (st[0] == ST_MR_WRITING) [*5] ##1 (st[0] == ST_IDLE))
    else $error("register write length wrong");
  a_pre_hold: assert property ((acc && cmd == CMD_PRE && (cmd_all || hit0)) |=>
    (st[0] == ST_PRECHARGE) ##1 (st[0] == ST_IDLE))
    else $error("precharge did not end after tRP");
  a_act_hold: assert property (hit0 && cmd == CMD_ACT |=>
    (st[0] == ST_ACTIVATING) ##1 (st[0] == ST_ACTIVE))
    else $error("activate did not reach active after tRCD");
  a_ap_close: assert property (hit0 && (cmd == CMD_RD || cmd == CMD_WR) && cmd_ap |=>
    (st[0] == ST_RD_AP || st[0] == ST_WR_AP) ##1 (st[0] == ST_IDLE))
    else $error("auto precharge did not close bank");
  a_bst_return: assert property (acc && cmd == CMD_BST && last_bank == 3'h0 &&
    (st[0] == ST_READING || st[0] == ST_WRITING) |=> (st[0] == ST_ACTIVE) && !burst_live)
    else $error("terminate did not return bank to active");
  a_cke_gate: assert property ((!cke_prev || !cke) && !burst_end |=>
    $stable(burst_live) && (st[0] == $past(st[0]) || $past(st[0]) != ST_ACTIVE))
    else $error("command acted without clock enable");

  c_reset_seq:  cover property (acc && cmd == CMD_MRW && cmd_rst_mr);
  c_read_bst:   cover property (hit0 && cmd == CMD_RD ##[1:20] acc && cmd == CMD_BST);
  c_mrr_active: cover property (st[0] == ST_MRR_ACTIVE);
  c_illegal:    cover property (cmd_illegal);

endmodule

// file: sim/lpbst_ctrl_model.sv
// Controller-side model: drives decoded commands and the clock enable
// toward the tracker. Assumes issue() is called just after a rising edge.
`timescale 1ns/1ps
module lpbst_ctrl_model (
  // Clock
  input  wire logic             clk_sys,
  // Command toward the device
  output lpbst_pkg::lpbst_cmd_t cmd,
  output logic [2:0]            cmd_bank,
  output logic                  cmd_all,
  output logic                  cmd_ap,
  output logic                  cmd_rst_mr,
  output logic                  cke
);
  import lpbst_pkg::*;

  // ==========================================================
  // Idle bus
  initial begin
    cmd        = CMD_NOP;
    cmd_bank   = 3'h0;
    cmd_all    = 1'h0;
    cmd_ap     = 1'h0;
    cmd_rst_mr = 1'h0;
    cke        = 1'h1;
  end

  // ==========================================================
  // Command issue
  task automatic issue(input lpbst_cmd_t c, input logic [2:0] b, input logic a = 1'h0,
                       input logic ap = 1'h0, input logic r = 1'h0);
    cmd        = c;
    cmd_bank   = b;
    cmd_all    = a;
    cmd_ap     = ap;
    cmd_rst_mr = r;
    // Held until the next issue or release_bus, so back-to-back calls
    // never drive the bus twice in one time step
    @(posedge clk_sys);
    #1;
  endtask

  // NOP before any idle edge, so a busy bank never sees a stray command
  task automatic release_bus();
    if (cmd != CMD_NOP) begin
      cmd        = CMD_NOP;
      // Qualifiers are don't-care under NOP; show them changed, not held
      cmd_bank   = ~cmd_bank;
      cmd_all    = ~cmd_all;
      cmd_ap     = ~cmd_ap;
      cmd_rst_mr = ~cmd_rst_mr;
    end
  endtask

  task automatic set_cke(input logic v);
    cke = v;
  endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench of the bank state tracker.
// Assumes default timing defines; the controller model drives the commands.
`timescale 1ns/1ps
`include "lpbst_params.svh"
module tb_top;
  import lpbst_pkg::*;

  typedef struct {
    lpbst_cmd_t   c;
    logic [2:0]   b;
    logic         a;
    logic         ap;
    logic         r;
    int           cb;
    lpbst_state_t mid;
    int           n;
    lpbst_state_t fin;
  } lpbst_row_t;

  logic         clk_sys;
  logic         sys_rst;
  logic         clk_en;
  logic         cke;
  lpbst_cmd_t   cmd;
  logic [2:0]   cmd_bank;
  logic         cmd_all;
  logic         cmd_ap;
  logic         cmd_rst_mr;
  logic         burst_end;
  logic [31:0]  bank_state;
  logic         all_idle;
  logic         burst_live;
  logic         cmd_illegal;
  int           mismatches;
  int           n_checks;
  lpbst_row_t   rows [10];

  // ==========================================================
  // Clock, model and design
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  lpbst_ctrl_model ctrl (.clk_sys(clk_sys), .cmd(cmd), .cmd_bank(cmd_bank),
    .cmd_all(cmd_all), .cmd_ap(cmd_ap), .cmd_rst_mr(cmd_rst_mr), .cke(cke));

  lpbst_tracker dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .cke(cke),
    .cmd(cmd), .cmd_bank(cmd_bank), .cmd_all(cmd_all), .cmd_ap(cmd_ap),
    .cmd_rst_mr(cmd_rst_mr), .burst_end(burst_end), .bank_state(bank_state),
    .all_idle(all_idle), .burst_live(burst_live), .cmd_illegal(cmd_illegal));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic step(input int n);
    ctrl.release_bus();
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic [3:0] st(input int b);
    return bank_state[4*b +: 4];
  endfunction

  // The flag is a one-cycle pulse right after the refused edge
  task automatic refused(input int b, input lpbst_state_t s);
    chk(st(b), s, "refused command moved the bank");
    chk(cmd_illegal, 1'h1, "refused command not flagged");
    step(1);
    chk(cmd_illegal, 1'h0, "illegal flag held too long");
  endtask

  task automatic pulse_end();
    burst_end = 1'h1;
    step(1);
    burst_end = 1'h0;
  endtask

  task automatic conclude();
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    sys_rst    = 1'h1;
    clk_en     = 1'h1;
    burst_end  = 1'h0;
    mismatches = 0;
    n_checks   = 0;
    rows[0] = '{CMD_REF, 3'h1, 1'h0, 1'h0, 1'h0, 1, ST_REF_PB, `LPBST_TRFCPB_CYC, ST_IDLE};
    rows[1] = '{CMD_REF, 3'h0, 1'h1, 1'h0, 1'h0, 6, ST_REF_AB, `LPBST_TRFCAB_CYC, ST_IDLE};
    rows[2] = '{CMD_MRR, 3'h0, 1'h0, 1'h0, 1'h0, 2, ST_MRR_IDLE, `LPBST_TMRR_CK, ST_IDLE};
    rows[3] = '{CMD_MRW, 3'h0, 1'h0, 1'h0, 1'h0, 3, ST_MR_WRITING, `LPBST_TMRW_CK, ST_IDLE};
    rows[4] = '{CMD_PRE, 3'h2, 1'h0, 1'h0, 1'h0, 2, ST_PRECHARGE, `LPBST_TRP_CYC, ST_IDLE};
    rows[5] = '{CMD_ACT, 3'h0, 1'h0, 1'h0, 1'h0, 0, ST_ACTIVATING, `LPBST_TRCD_CYC, ST_ACTIVE};
    rows[6] = '{CMD_MRR, 3'h0, 1'h0, 1'h0, 1'h0, 0, ST_MRR_ACTIVE, `LPBST_TMRR_CK, ST_ACTIVE};
    rows[7] = '{CMD_PRE, 3'h0, 1'h0, 1'h0, 1'h0, 0, ST_PRECHARGE, `LPBST_TRP_CYC, ST_IDLE};
    rows[8] = '{CMD_ACT, 3'h3, 1'h0, 1'h0, 1'h0, 3, ST_ACTIVATING, `LPBST_TRCD_CYC, ST_ACTIVE};
    rows[9] = '{CMD_PRE, 3'h0, 1'h1, 1'h0, 1'h0, 3, ST_PRECHARGE, `LPBST_TRP_CYC, ST_IDLE};
    step(3);
    chk(bank_state, {8{ST_POWER_ON}}, "reset bank states");
    chk({all_idle, burst_live, cmd_illegal}, 3'h0, "reset flags");
    step(5);
    sys_rst = 1'h0;
    step(2);
    ctrl.issue(CMD_ACT, 3'h0);
    refused(0, ST_POWER_ON);
    ctrl.issue(CMD_MRW, 3'h0, 1'h0, 1'h0, 1'h1);
    chk(st(7), ST_RESETTING, "reset entry");
    step(`LPBST_TINIT5_CYC - 1);
    chk(st(7), ST_RESETTING, "resetting too short");
    step(1);
    chk(st(7), ST_IDLE, "resetting too long");
    // Timed states from the table
    foreach (rows[i]) begin
      ctrl.issue(rows[i].c, rows[i].b, rows[i].a, rows[i].ap, rows[i].r);
      for (int k = 0; k < rows[i].n; k++) begin
        chk(st(rows[i].cb), rows[i].mid, "timed state");
        step(1);
      end
      chk(st(rows[i].cb), rows[i].fin, "state after timer");
    end
    // Auto-precharge read: bank closes while the burst still runs
    ctrl.issue(CMD_ACT, 3'h4);
    step(`LPBST_TRCD_CYC);
    ctrl.issue(CMD_RD, 3'h4, 1'h0, 1'h1);
    chk(st(4), ST_RD_AP, "read with auto precharge");
    chk(burst_live, 1'h1, "auto precharge burst");
    step(`LPBST_TRP_CYC);
    chk(st(4), ST_IDLE, "auto precharge close");
    ctrl.issue(CMD_ACT, 3'h4);
    refused(4, ST_IDLE);
    pulse_end();
    chk(burst_live, 1'h0, "burst end");
    // Plain bursts, terminate and cross-direction refusals
    ctrl.issue(CMD_ACT, 3'h0);
    step(`LPBST_TRCD_CYC);
    ctrl.issue(CMD_RD, 3'h0);
    chk(st(0), ST_READING, "read burst");
    ctrl.issue(CMD_ACT, 3'h2);
    chk(st(2), ST_ACTIVATING, "activate beside a burst");
    ctrl.issue(CMD_WR, 3'h0);
    refused(0, ST_READING);
    ctrl.issue(CMD_BST, 3'h5);
    chk(st(0), ST_ACTIVE, "terminate any bank");
    chk(burst_live, 1'h0, "terminate clears burst");
    ctrl.issue(CMD_BST, 3'h0);
    refused(0, ST_ACTIVE);
    ctrl.issue(CMD_WR, 3'h0);
    chk(st(0), ST_WRITING, "write burst");
    ctrl.issue(CMD_RD, 3'h0);
    refused(0, ST_WRITING);
    pulse_end();
    chk(st(0), ST_ACTIVE, "write end");
    ctrl.issue(CMD_ACT, 3'h0);
    refused(0, ST_ACTIVE);
    ctrl.issue(CMD_MRW, 3'h0);
    refused(0, ST_ACTIVE);
    chk(all_idle, 1'h0, "open bank not idle");
    ctrl.issue(CMD_PRE, 3'h0, 1'h1);
    step(`LPBST_TRP_CYC + 1);
    chk(all_idle, 1'h1, "all idle after close");
    // Clock enable of the memory low: command ignored
    ctrl.set_cke(1'h0);
    ctrl.issue(CMD_ACT, 3'h2);
    chk(st(2), ST_IDLE, "command with clock enable low");
    chk(cmd_illegal, 1'h0, "ignored command flagged");
    ctrl.set_cke(1'h1);
    step(2);
    // Frozen clock enable holds the refresh timer
    ctrl.issue(CMD_REF, 3'h1);
    clk_en = 1'h0;
    step(5);
    chk(st(1), ST_REF_PB, "frozen timer");
    clk_en = 1'h1;
    step(`LPBST_TRFCPB_CYC - 1);
    chk(st(1), ST_REF_PB, "refresh after freeze");
    step(1);
    chk(st(1), ST_IDLE, "refresh end after freeze");
    // Reset from idle, register read while resetting
    ctrl.issue(CMD_MRW, 3'h0, 1'h0, 1'h0, 1'h1);
    chk(st(0), ST_RESETTING, "reset from idle");
    step(3);
    ctrl.issue(CMD_MRR, 3'h0);
    chk(st(0), ST_MRR_RESET, "register read in reset");
    step(`LPBST_TMRR_CK);
    chk(st(0), ST_IDLE, "register read in reset end");
    // Reset in mid-run
    sys_rst = 1'h1;
    step(1);
    chk(bank_state, {8{ST_POWER_ON}}, "second reset");
    sys_rst = 1'h0;
    // First edge after release has no earlier clock-enable sample
    ctrl.issue(CMD_MRW, 3'h0, 1'h0, 1'h0, 1'h1);
    chk(st(0), ST_POWER_ON, "command at first edge after reset");
    chk(cmd_illegal, 1'h0, "first-edge command flagged");
    ctrl.issue(CMD_MRW, 3'h0, 1'h0, 1'h0, 1'h1);
    chk(st(0), ST_RESETTING, "reset entry after second reset");
    conclude();
  end
endmodule
